// [rtl/hyp_trap_cfg.svh]
`ifndef HYP_TRAP_CFG_SVH
`define HYP_TRAP_CFG_SVH

// Encoding of the feature-trap register in the coprocessor space.
`define FTC_COPROC 4'hf
`define FTC_OPC1   3'h4
`define FTC_CRN    4'h1
`define FTC_CRM    4'h1
`define FTC_OPC2   3'h2

// Encoding of the configuration register in the coprocessor space.
`define HCC_COPROC 4'hf
`define HCC_OPC1   3'h4
`define HCC_CRN    4'h1
`define HCC_CRM    4'h1
`define HCC_OPC2   3'h0

// Coprocessor number of the system control space.
`define SYS_COPROC 4'hf

// Field positions of the configuration register.
`define MEM_RD_TRAP_BIT   30
`define HYPCALL_DIS_BIT   29
`define GEN_EXC_TRAP_BIT  27
`define MEM_WR_TRAP_BIT   26
`define UNIF_MAINT_BIT    24
`define COH_MAINT_BIT     23
`define SETWAY_MAINT_BIT  22
`define AUX_TRAP_BIT      21
`define IMPDEF_TRAP_BIT   20
`define ID3_TRAP_BIT      18
`define VSERR_PEND_BIT    8
`define VIRQ_PEND_BIT     7
`define VFIQ_PEND_BIT     6
`define SERR_OVR_BIT      5
`define IRQ_OVR_BIT       4
`define FIQ_OVR_BIT       3

// Field positions and fixed bits of the feature-trap register.
`define FP_TRAP_BIT       10
`define FP_TRAP_MIRROR    11
`define FTC_RES1          32'h000033ff

// Writable bits of the configuration register; the rest read as zero.
`define HCC_WMASK         32'h6df7ffff

// Reset values.
`define HCC_RST           32'h00000000
`define FTC_TRAP_RST      1'b0

// Per-CRm masks of the implementation-defined encodings.
`define IMPDEF_C9_MASK    16'h01e7
`define IMPDEF_C10_MASK   16'h0113
`define IMPDEF_C11_MASK   16'h81ff

// Per-opc2 masks of the ID group 3 encodings, mandatory and optional.
`define ID3_C3_MASK       8'h07
`define ID3_C467_MASK     8'h03
`define ID3_C5_MASK       8'h33
`define ID3_C2_OPT        8'h80
`define ID3_C3_OPT        8'hf8
`define ID3_C467_OPT      8'hfc
`define ID3_C5_OPT        8'hcc

// Implementation choices.
`define IMPDEF_TRAP_EL0   1'b1
`define ID3_TRAP_OPT      1'b0

`endif

// [rtl/hyp_trap_pkg.sv]
package hyp_trap_pkg;

  typedef logic [1:0] el_t;

  typedef enum logic [3:0] {
    OP_SYSREG = 4'h0,
    OP_MEMCTL = 4'h1,
    OP_AUXCTL = 4'h2,
    OP_FP     = 4'h3,
    OP_HVC    = 4'h4,
    OP_CMO_PU = 4'h5,
    OP_CMO_PC = 4'h6,
    OP_CMO_SW = 4'h7,
    OP_EXC    = 4'h8,
    OP_ERET   = 4'h9
  } op_e;

  typedef enum logic [2:0] {
    ACT_NONE        = 3'h0,
    ACT_HYP_TRAP    = 3'h1,
    ACT_UNDEF_HYP   = 3'h2,
    ACT_UNDEF_LOCAL = 3'h3,
    ACT_UNDEF_UND   = 3'h4,
    ACT_ROUTE_EL2   = 3'h5,
    ACT_ILLEGAL_RET = 3'h6
  } act_e;

  typedef struct packed {
    logic [3:0] coproc;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic       is_write;
  } sysreg_s;

  typedef struct packed {
    op_e         op;
    el_t         el;
    sysreg_s     sr;
    logic        lower_trap;
    logic [31:0] wdata;
  } chk_s;

  typedef struct packed {
    logic ftc;
    logic hcc;
    logic impdef;
    logic id3;
  } regcls_s;

  typedef struct packed {
    act_e        act;
    logic [31:0] rdata;
  } res_s;

endpackage

// [rtl/sysreg_decode.sv]
`timescale 1ns/1ps
`include "hyp_trap_cfg.svh"

module sysreg_decode
  import hyp_trap_pkg::*;
(
  // Access encoding.
  input  sysreg_s sr,
  // Register classes.
  output regcls_s cls
);

  wire        sys_space;
  wire [15:0] impdef_mask;
  wire [7:0]  id3_mask;
  wire [7:0]  id3_opt;
  wire        crm_467;
  wire        id3_base;

  assign sys_space = (sr.coproc == `SYS_COPROC);

  assign cls.ftc = (sr.coproc == `FTC_COPROC) && (sr.opc1 == `FTC_OPC1) &&
                   (sr.crn == `FTC_CRN) && (sr.crm == `FTC_CRM) &&
                   (sr.opc2 == `FTC_OPC2);
  assign cls.hcc = (sr.coproc == `HCC_COPROC) && (sr.opc1 == `HCC_OPC1) &&
                   (sr.crn == `HCC_CRN) && (sr.crm == `HCC_CRM) &&
                   (sr.opc2 == `HCC_OPC2);

  // Every opc1 and opc2 value is covered, so only CRn and CRm select.
  assign impdef_mask = (sr.crn == 4'h9) ? `IMPDEF_C9_MASK :
                       (sr.crn == 4'ha) ? `IMPDEF_C10_MASK :
                       (sr.crn == 4'hb) ? `IMPDEF_C11_MASK : 16'h0000;
  assign cls.impdef  = sys_space && impdef_mask[sr.crm];

  assign crm_467  = (sr.crm == 4'h4) || (sr.crm == 4'h6) || (sr.crm == 4'h7);
  assign id3_base = sys_space && (sr.opc1 == 3'h0) && (sr.crn == 4'h0);
  assign id3_mask = (sr.crm == 4'h3) ? `ID3_C3_MASK :
                    (sr.crm == 4'h5) ? `ID3_C5_MASK :
                    crm_467          ? `ID3_C467_MASK : 8'h00;
  assign id3_opt  = (sr.crm == 4'h2) ? `ID3_C2_OPT :
                    (sr.crm == 4'h3) ? `ID3_C3_OPT :
                    (sr.crm == 4'h5) ? `ID3_C5_OPT :
                    crm_467          ? `ID3_C467_OPT : 8'h00;
  assign cls.id3  = id3_base &&
                    (id3_mask[sr.opc2] || (`ID3_TRAP_OPT && id3_opt[sr.opc2]));

endmodule

// [rtl/hyp_trap_config.sv]
`timescale 1ns/1ps
`include "hyp_trap_cfg.svh"

// Overview of operation
// - Floating-point trap bit set traps FP/vector use unless an EL1 control traps.
// - Trapped use gives Hyp Trap from EL0/EL1, undefined-to-Hyp from Hyp.
// - FP trap covers FP instructions, FP register file and FP system registers.
// - Feature-trap register is reached at coproc 1111, 100, 0001, 0001, 010.
// - Configuration register is 32 bits; bits 31, 28, 25, 19 read zero.
// - Memory-control read trap (bit 30) traps EL1 reads of memory controls.
// - Hypercall disable (bit 29) makes hypercalls undefined at EL2 and EL1.
// - Hypercalls at EL0 are always undefined.
// - General exception trap (bit 27) routes EL1-bound exceptions to EL2.
// - With it set, region enable acts 0 and mask overrides act 1.
// - With it set, virtual interrupts are off and returns to EL1 illegal.
// - With it set, the three debug-access trap bits act as 1.
// - Memory-control write trap (bit 26) traps EL1 writes of memory controls.
// - Unification maintenance trap (bit 24) traps EL1 point-of-unification ops.
// - Coherency maintenance trap (bit 23) traps EL1 point-of-coherency ops.
// - Set/way maintenance trap (bit 22) traps EL1 set/way ops.
// - Cache maintenance at EL0 is undefined, ahead of any trap to EL2.
// - Auxiliary-control trap (bit 21) traps EL1 auxiliary control accesses.
// - Implementation-defined trap (bit 20) traps EL1 c9/c10/c11 listed accesses.
// - EL0 such accesses either trap to Hyp or are undefined to Undefined mode.
// - ID group 3 trap (bit 18) traps EL1 reads of feature ID registers.
// - Trap fields reset to zero.

module hyp_trap_config
  import hyp_trap_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Check request from the pipeline.
  input  wire logic        chk_valid,
  input  chk_s             chk,
  // Check answer.
  output logic             res_valid,
  output res_s             res,
  // State seen by other logic.
  input  wire logic        region_enable_bit,
  input  wire logic [2:0]  hyp_debug_control,
  output logic             eff_region_enable,
  output logic [2:0]       eff_mask_override,
  output logic [2:0]       eff_virt_pending,
  output logic [2:0]       eff_debug_trap,
  output logic             fp_vector_trap,
  output logic [31:0]      hyp_configuration_control
);

  logic        fp_trap_q;
  logic [31:0] hcc_q;
  logic        res_valid_q;
  res_s        res_q;
  logic        eff_region_q;
  logic [2:0]  eff_mask_q;
  logic [2:0]  eff_virt_q;
  logic [2:0]  eff_dbg_q;

  regcls_s     cls;

  wire         el0;
  wire         el1;
  wire         el2;
  wire         is_wr;
  wire         general_exception_trap;
  wire         own_reg;
  wire         reg_wr;
  wire         ftc_wr;
  wire         hcc_wr;
  wire [31:0]  ftc_rd;
  wire [31:0]  rd_val;
  wire [2:0]   mask_raw;
  wire [2:0]   virt_raw;
  wire         cmo_bit;
  wire         mem_bit;
  act_e        act_fp;
  act_e        act_hvc;
  act_e        act_cmo;
  act_e        act_sys;
  act_e        act_imp;
  act_e        act_sel;

  sysreg_decode u_dec (
    .sr  (chk.sr),
    .cls (cls)
  );

  assign el0   = (chk.el == 2'h0);
  assign el1   = (chk.el == 2'h1);
  assign el2   = (chk.el == 2'h2);
  assign is_wr = chk.sr.is_write;
  assign general_exception_trap   = hcc_q[`GEN_EXC_TRAP_BIT];

  // Only Hyp mode reaches these two registers.
  assign own_reg = cls.ftc || cls.hcc;
  assign reg_wr  = chk_valid && (chk.op == OP_SYSREG) && el2 && is_wr;
  assign ftc_wr  = reg_wr && cls.ftc;
  assign hcc_wr  = reg_wr && cls.hcc;

  // The unused mirror bit always reads back equal to the trap bit.
  assign ftc_rd = `FTC_RES1 | ({31'h0, fp_trap_q} << `FP_TRAP_BIT) |
                  ({31'h0, fp_trap_q} << `FP_TRAP_MIRROR);
  assign rd_val = !el2   ? 32'h00000000 :
                  cls.ftc ? ftc_rd :
                  cls.hcc ? hcc_q : 32'h00000000;

  // An EL1-level access control already claims the access, so no Hyp trap.
  assign act_fp = (!fp_trap_q || chk.lower_trap) ? ACT_NONE :
                  el2 ? ACT_UNDEF_HYP : ACT_HYP_TRAP;

  assign act_hvc = el0 ? ACT_UNDEF_LOCAL :
                   hcc_q[`HYPCALL_DIS_BIT] ? ACT_UNDEF_LOCAL : ACT_NONE;

  assign cmo_bit = (chk.op == OP_CMO_PU) ? hcc_q[`UNIF_MAINT_BIT] :
                   (chk.op == OP_CMO_PC) ? hcc_q[`COH_MAINT_BIT] :
                   hcc_q[`SETWAY_MAINT_BIT];
  assign act_cmo = el0 ? ACT_UNDEF_LOCAL :
                   (el1 && cmo_bit) ? ACT_HYP_TRAP : ACT_NONE;

  assign mem_bit = is_wr ? hcc_q[`MEM_WR_TRAP_BIT] :
                   hcc_q[`MEM_RD_TRAP_BIT];

  // EL0 either traps to Hyp or is undefined to Undefined mode.
  assign act_imp = el1 ? ACT_HYP_TRAP :
                   el0 ? (`IMPDEF_TRAP_EL0 ? ACT_HYP_TRAP : ACT_UNDEF_UND) :
                   ACT_NONE;

  assign act_sys = own_reg ? (el2 ? ACT_NONE : ACT_UNDEF_LOCAL) :
                   (cls.impdef && hcc_q[`IMPDEF_TRAP_BIT]) ? act_imp :
                   (cls.id3 && el1 && !is_wr && hcc_q[`ID3_TRAP_BIT]) ?
                   ACT_HYP_TRAP : ACT_NONE;

  always_comb begin
    act_sel = ACT_NONE;
    unique case (chk.op)
      OP_SYSREG: act_sel = act_sys;
      OP_MEMCTL: act_sel = (el1 && mem_bit) ? ACT_HYP_TRAP : ACT_NONE;
      OP_AUXCTL: act_sel = (el1 && hcc_q[`AUX_TRAP_BIT]) ? ACT_HYP_TRAP : ACT_NONE;
      OP_FP:     act_sel = act_fp;
      OP_HVC:    act_sel = act_hvc;
      OP_CMO_PU: act_sel = act_cmo;
      OP_CMO_PC: act_sel = act_cmo;
      OP_CMO_SW: act_sel = act_cmo;
      OP_EXC:    act_sel = general_exception_trap ? ACT_ROUTE_EL2 : ACT_NONE;
      OP_ERET:   act_sel = general_exception_trap ? ACT_ILLEGAL_RET : ACT_NONE;
      default:   act_sel = ACT_NONE;
    endcase
  end

  // Effective views; direct reads still see the stored bits.
  assign mask_raw = {hcc_q[`FIQ_OVR_BIT], hcc_q[`IRQ_OVR_BIT], hcc_q[`SERR_OVR_BIT]};
  assign virt_raw = {hcc_q[`VFIQ_PEND_BIT], hcc_q[`VIRQ_PEND_BIT],
                     hcc_q[`VSERR_PEND_BIT]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_trap_q <= `FTC_TRAP_RST;
      hcc_q     <= `HCC_RST;
    end else begin
      if (ftc_wr) begin
        fp_trap_q <= chk.wdata[`FP_TRAP_BIT];
      end
      if (hcc_wr) begin
        hcc_q <= chk.wdata & `HCC_WMASK;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_valid_q <= 1'b0;
      res_q       <= '{act: ACT_NONE, rdata: 32'h00000000};
    end else begin
      res_valid_q <= chk_valid;
      res_q.act   <= chk_valid ? act_sel : ACT_NONE;
      res_q.rdata <= (chk_valid && (chk.op == OP_SYSREG) && !is_wr) ? rd_val : 32'h00000000;
    end
  end

  // Virtual interrupts need their override; all three shut off under the trap.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eff_region_q <= 1'b0;
      eff_mask_q   <= 3'h0;
      eff_virt_q   <= 3'h0;
      eff_dbg_q    <= 3'h0;
    end else begin
      eff_region_q <= region_enable_bit && !general_exception_trap;
      eff_mask_q   <= mask_raw | {3{general_exception_trap}};
      eff_virt_q   <= virt_raw & mask_raw & {3{!general_exception_trap}};
      eff_dbg_q    <= hyp_debug_control | {3{general_exception_trap}};
    end
  end

  assign res_valid                 = res_valid_q;
  assign res                       = res_q;
  assign eff_region_enable         = eff_region_q;
  assign eff_mask_override         = eff_mask_q;
  assign eff_virt_pending          = eff_virt_q;
  assign eff_debug_trap            = eff_dbg_q;
  assign fp_vector_trap            = fp_trap_q;
  assign hyp_configuration_control = hcc_q;

  property p_fp_trap;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_FP && fp_trap_q && !chk.lower_trap && !el2)
      |=> (res_valid && res.act == ACT_HYP_TRAP);
  endproperty
  a_fp_trap: assert property (p_fp_trap) else $error("fp use not trapped to hyp");

  property p_fp_hyp;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_FP && fp_trap_q && !chk.lower_trap && el2)
      |=> (res.act == ACT_UNDEF_HYP);
  endproperty
  a_fp_hyp: assert property (p_fp_hyp) else $error("fp use in hyp not undefined");

  property p_fp_lower;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_FP && (chk.lower_trap || !fp_trap_q))
      |=> (res.act == ACT_NONE);
  endproperty
  a_fp_lower: assert property (p_fp_lower) else $error("fp trap overrode el1 control");

  property p_ftc_wr;
    @(posedge clk) disable iff (rst)
    ftc_wr |=> (fp_vector_trap == $past(chk.wdata[`FP_TRAP_BIT]));
  endproperty
  a_ftc_wr: assert property (p_ftc_wr) else $error("feature trap write lost");

  property p_res0;
    @(posedge clk) disable iff (rst)
    hcc_wr |=> ((hyp_configuration_control & ~`HCC_WMASK) == 32'h00000000);
  endproperty
  a_res0: assert property (p_res0) else $error("reserved config bit set");

  property p_hvc_el0;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_HVC && el0) |=> (res.act == ACT_UNDEF_LOCAL);
  endproperty
  a_hvc_el0: assert property (p_hvc_el0) else $error("el0 hypercall not undefined");

  property p_hvc_dis;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_HVC && !el0)
      |=> (res.act == ($past(hcc_q[`HYPCALL_DIS_BIT]) ? ACT_UNDEF_LOCAL : ACT_NONE));
  endproperty
  a_hvc_dis: assert property (p_hvc_dis) else $error("hypercall disable ignored");

  property p_route;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_EXC && general_exception_trap) |=> (res.act == ACT_ROUTE_EL2);
  endproperty
  a_route: assert property (p_route) else $error("exception not routed to el2");

  property p_tge_view;
    @(posedge clk) disable iff (rst)
    general_exception_trap |=> (eff_mask_override == 3'h7 && !eff_region_enable && eff_virt_pending == 3'h0);
  endproperty
  a_tge_view: assert property (p_tge_view) else $error("tge effective view wrong");

  property p_dbg;
    @(posedge clk) disable iff (rst)
    general_exception_trap |=> (eff_debug_trap == 3'h7);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug traps not forced");

  property p_cmo_el0;
    @(posedge clk) disable iff (rst)
    (chk_valid && (chk.op == OP_CMO_PU || chk.op == OP_CMO_PC || chk.op == OP_CMO_SW) && el0)
      |=> (res.act == ACT_UNDEF_LOCAL);
  endproperty
  a_cmo_el0: assert property (p_cmo_el0) else $error("el0 cache op not undefined");

  property p_aux;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_AUXCTL && el1 && hcc_q[`AUX_TRAP_BIT])
      |=> (res.act == ACT_HYP_TRAP);
  endproperty
  a_aux: assert property (p_aux) else $error("aux control access not trapped");

  property p_mem_rd;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_MEMCTL && el1 && !is_wr && hcc_q[`MEM_RD_TRAP_BIT])
      |=> (res.act == ACT_HYP_TRAP);
  endproperty
  a_mem_rd: assert property (p_mem_rd) else $error("mem ctrl read not trapped");

  property p_mem_wr;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_MEMCTL && el1 && is_wr && hcc_q[`MEM_WR_TRAP_BIT])
      |=> (res.act == ACT_HYP_TRAP);
  endproperty
  a_mem_wr: assert property (p_mem_wr) else $error("mem ctrl write not trapped");

  property p_impdef;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_SYSREG && el1 && cls.impdef && hcc_q[`IMPDEF_TRAP_BIT])
      |=> (res.act == ACT_HYP_TRAP);
  endproperty
  a_impdef: assert property (p_impdef) else $error("impdef access not trapped");

  property p_id3;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_SYSREG && el1 && !is_wr && cls.id3 && hcc_q[`ID3_TRAP_BIT])
      |=> (res.act == ACT_HYP_TRAP);
  endproperty
  a_id3: assert property (p_id3) else $error("id group 3 read not trapped");

  property p_eret;
    @(posedge clk) disable iff (rst)
    (chk_valid && chk.op == OP_ERET && general_exception_trap) |=> (res.act == ACT_ILLEGAL_RET);
  endproperty
  a_eret: assert property (p_eret) else $error("return to el1 not illegal");

endmodule

// [bench/hyp_trap_config_tb.sv]
`timescale 1ns/1ps
`include "hyp_trap_cfg.svh"

module hyp_trap_config_tb
  import hyp_trap_pkg::*;
;
  typedef struct packed {
    logic [31:0] cfg;
    op_e         op;
    el_t         el;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic        w;
    act_e        exp;
    logic        chk0;
    act_e        exp0;
  } case_s;

  logic        clk;
  logic        rst;
  logic        chk_valid;
  chk_s        chk;
  logic        res_valid;
  res_s        res;
  logic        region_enable_bit;
  logic [2:0]  hyp_debug_control;
  logic        eff_region_enable;
  logic [2:0]  eff_mask_override;
  logic [2:0]  eff_virt_pending;
  logic [2:0]  eff_debug_trap;
  logic        fp_vector_trap;
  logic [31:0] hyp_configuration_control;
  int          n_errors;
  int          n_tests;
  int          cycles;
  case_s       tbl [19];
  act_e        a;
  logic [31:0] r;

  hyp_trap_config dut_u (
    .clk                       (clk),
    .rst                       (rst),
    .chk_valid                 (chk_valid),
    .chk                       (chk),
    .res_valid                 (res_valid),
    .res                       (res),
    .region_enable_bit         (region_enable_bit),
    .hyp_debug_control         (hyp_debug_control),
    .eff_region_enable         (eff_region_enable),
    .eff_mask_override         (eff_mask_override),
    .eff_virt_pending          (eff_virt_pending),
    .eff_debug_trap            (eff_debug_trap),
    .fp_vector_trap            (fp_vector_trap),
    .hyp_configuration_control (hyp_configuration_control)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang shows up as a mismatch rather than a silent stall.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic sysreg_s mk_sr(input logic [3:0] n, input logic [3:0] m,
                                    input logic [2:0] o2, input logic w);
    return '{coproc: `SYS_COPROC, opc1: 3'h0, crn: n, crm: m, opc2: o2, is_write: w};
  endfunction

  function automatic sysreg_s own_sr(input logic [2:0] o2, input logic w);
    return '{coproc: `HCC_COPROC, opc1: `HCC_OPC1, crn: `HCC_CRN, crm: `HCC_CRM,
             opc2: o2, is_write: w};
  endfunction

  // Called at a falling edge; the request is dropped before the next one so
  // that the answer and the idle cycle after it are both looked at.
  task automatic access(input op_e op, input el_t el, input sysreg_s sr, input logic lower,
                        input logic [31:0] wd, output act_e act, output logic [31:0] rd);
    chk = '{op: op, el: el, sr: sr, lower_trap: lower, wdata: wd};
    chk_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("res_valid", {31'h0, res_valid}, 32'h1);
    act = res.act;
    rd = res.rdata;
    chk_valid = 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("res_valid idle", {31'h0, res_valid}, 32'h0);
    check("act idle", {29'h0, res.act}, {29'h0, ACT_NONE});
  endtask

  task automatic wr_own(input logic [2:0] o2, input logic [31:0] d);
    act_e        x;
    logic [31:0] y;
    access(OP_SYSREG, 2'h2, own_sr(o2, 1'b1), 1'b0, d, x, y);
  endtask

  task automatic chk_act(input string name, input act_e seen, input act_e exp);
    check(name, {29'h0, seen}, {29'h0, exp});
  endtask

  initial begin
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    rst = 1'b1;
    chk_valid = 1'b0;
    chk = '0;
    region_enable_bit = 1'b1;
    hyp_debug_control = 3'h2;
    tbl[0]  = '{32'h40000000, OP_MEMCTL, 2'h1, 4'h0, 4'h0, 1'b0, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[1]  = '{32'h40000000, OP_MEMCTL, 2'h1, 4'h0, 4'h0, 1'b1, ACT_NONE, 1'b1, ACT_NONE};
    tbl[2]  = '{32'h04000000, OP_MEMCTL, 2'h1, 4'h0, 4'h0, 1'b1, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[3]  = '{32'h20000000, OP_HVC, 2'h1, 4'h0, 4'h0, 1'b0, ACT_UNDEF_LOCAL, 1'b1, ACT_NONE};
    tbl[4]  = '{32'h20000000, OP_HVC, 2'h2, 4'h0, 4'h0, 1'b0, ACT_UNDEF_LOCAL, 1'b1, ACT_NONE};
    tbl[5]  = '{32'h20000000, OP_HVC, 2'h0, 4'h0, 4'h0, 1'b0, ACT_UNDEF_LOCAL, 1'b1,
                ACT_UNDEF_LOCAL};
    tbl[6]  = '{32'h08000000, OP_EXC, 2'h1, 4'h0, 4'h0, 1'b0, ACT_ROUTE_EL2, 1'b1, ACT_NONE};
    tbl[7]  = '{32'h08000000, OP_ERET, 2'h1, 4'h0, 4'h0, 1'b0, ACT_ILLEGAL_RET, 1'b1, ACT_NONE};
    tbl[8]  = '{32'h01000000, OP_CMO_PU, 2'h1, 4'h0, 4'h0, 1'b0, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[9]  = '{32'h00800000, OP_CMO_PC, 2'h1, 4'h0, 4'h0, 1'b0, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[10] = '{32'h00400000, OP_CMO_SW, 2'h1, 4'h0, 4'h0, 1'b0, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[11] = '{32'h01c00000, OP_CMO_PC, 2'h0, 4'h0, 4'h0, 1'b0, ACT_UNDEF_LOCAL, 1'b1,
                ACT_UNDEF_LOCAL};
    tbl[12] = '{32'h00200000, OP_AUXCTL, 2'h1, 4'h0, 4'h0, 1'b1, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[13] = '{32'h00100000, OP_SYSREG, 2'h1, 4'h9, 4'h0, 1'b1, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[14] = '{32'h00100000, OP_SYSREG, 2'h1, 4'hb, 4'hf, 1'b0, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[15] = '{32'h00100000, OP_SYSREG, 2'h0, 4'ha, 4'h8, 1'b0, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[16] = '{32'h00100000, OP_SYSREG, 2'h1, 4'ha, 4'h3, 1'b0, ACT_NONE, 1'b1, ACT_NONE};
    tbl[17] = '{32'h00040000, OP_SYSREG, 2'h1, 4'h0, 4'h3, 1'b0, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    tbl[18] = '{32'h00040000, OP_SYSREG, 2'h1, 4'h0, 4'h7, 1'b0, ACT_HYP_TRAP, 1'b1, ACT_NONE};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("cfg reset", hyp_configuration_control, `HCC_RST);
    check("fp reset", {31'h0, fp_vector_trap}, 32'h0);
    access(OP_SYSREG, 2'h2, own_sr(`FTC_OPC2, 1'b0), 1'b0, 32'h0, a, r);
    check("ftc read reset", r, 32'h000033ff);
    wr_own(`HCC_OPC2, 32'hffffffff);
    check("cfg port", hyp_configuration_control, 32'h6df7ffff);
    access(OP_SYSREG, 2'h2, own_sr(`HCC_OPC2, 1'b0), 1'b0, 32'h0, a, r);
    check("cfg read", r, 32'h6df7ffff);
    access(OP_SYSREG, 2'h1, own_sr(`HCC_OPC2, 1'b1), 1'b0, 32'h0, a, r);
    chk_act("cfg el1 write", a, ACT_UNDEF_LOCAL);
    check("cfg kept", hyp_configuration_control, 32'h6df7ffff);
    // Floating-point trap and its exception kinds per level.
    wr_own(`FTC_OPC2, 32'h00000400);
    check("fp trap", {31'h0, fp_vector_trap}, 32'h1);
    access(OP_SYSREG, 2'h2, own_sr(`FTC_OPC2, 1'b0), 1'b0, 32'h0, a, r);
    check("ftc read", r, 32'h00003fff);
    for (int e = 0; e < 3; e++) begin
      access(OP_FP, e[1:0], mk_sr(4'h0, 4'h0, 3'h0, 1'b0), 1'b0, 32'h0, a, r);
      chk_act("fp act", a, (e == 2) ? ACT_UNDEF_HYP : ACT_HYP_TRAP);
    end
    access(OP_FP, 2'h1, mk_sr(4'h0, 4'h0, 3'h0, 1'b0), 1'b1, 32'h0, a, r);
    chk_act("fp lower", a, ACT_NONE);
    wr_own(`FTC_OPC2, 32'h00000800);
    check("fp mirror only", {31'h0, fp_vector_trap}, 32'h0);
    access(OP_FP, 2'h1, mk_sr(4'h0, 4'h0, 3'h0, 1'b0), 1'b0, 32'h0, a, r);
    chk_act("fp off", a, ACT_NONE);
    // Each trap field alone, the three maintenance fields together for EL0, then the same request with the fields clear.
    foreach (tbl[i]) begin
      wr_own(`HCC_OPC2, tbl[i].cfg);
      access(tbl[i].op, tbl[i].el, mk_sr(tbl[i].crn, tbl[i].crm, 3'h1, tbl[i].w), 1'b0,
             32'h0, a, r);
      chk_act("trap on", a, tbl[i].exp);
      wr_own(`HCC_OPC2, 32'h0);
      access(tbl[i].op, tbl[i].el, mk_sr(tbl[i].crn, tbl[i].crm, 3'h1, tbl[i].w), 1'b0,
             32'h0, a, r);
      if (tbl[i].chk0) chk_act("trap off", a, tbl[i].exp0);
    end
    // Effective views with the general exception trap set and clear.
    wr_own(`HCC_OPC2, 32'h08000000);
    check("eff region", {31'h0, eff_region_enable}, 32'h0);
    check("eff mask", {29'h0, eff_mask_override}, 32'h7);
    check("eff virt", {29'h0, eff_virt_pending}, 32'h0);
    check("eff debug", {29'h0, eff_debug_trap}, 32'h7);
    check("cfg direct", hyp_configuration_control, 32'h08000000);
    wr_own(`HCC_OPC2, 32'h000001f8);
    check("eff region off", {31'h0, eff_region_enable}, 32'h1);
    check("eff mask off", {29'h0, eff_mask_override}, 32'h7);
    check("eff virt on", {29'h0, eff_virt_pending}, 32'h7);
    check("eff debug off", {29'h0, eff_debug_trap}, 32'h2);
    wr_own(`HCC_OPC2, 32'h080001f8);
    check("eff virt tge", {29'h0, eff_virt_pending}, 32'h0);
    wr_own(`HCC_OPC2, 32'h000001c0);
    check("eff virt nomask", {29'h0, eff_virt_pending}, 32'h0);
    check("eff mask none", {29'h0, eff_mask_override}, 32'h0);
    // The stored inputs must pass through when the trap is clear.
    region_enable_bit = 1'b0;
    hyp_debug_control = 3'h5;
    @(negedge clk);
    check("eff region low", {31'h0, eff_region_enable}, 32'h0);
    check("eff debug pass", {29'h0, eff_debug_trap}, 32'h5);
    tally_and_finish();
  end
endmodule
